// ### ifs_pkg.sv
// Package for the in-application flash programming sequencer: map, fields, states, timing.
package ifs_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0] IFS_OFF_CTRL = 6'h00;
  localparam logic [5:0] IFS_OFF_CLEAR = 6'h04;
  localparam logic [5:0] IFS_OFF_ADDR_LOW = 6'h08;
  localparam logic [5:0] IFS_OFF_ADDR_HIGH = 6'h0C;
  localparam logic [5:0] IFS_OFF_DATA_LOW = 6'h10;
  localparam logic [5:0] IFS_OFF_DATA_HIGH = 6'h14;
  localparam logic [5:0] IFS_OFF_KEY_FIRST = 6'h18;
  localparam logic [5:0] IFS_OFF_KEY_LAST = 6'h2C;

  // Unlock key, first key register in the top byte
  localparam int IFS_KEY_COUNT = 6;
  localparam logic [47:0] IFS_KEY_PATTERN = 48'h000DC3040940;

  // Operation select codes
  localparam logic [2:0] IFS_MODE_WRITE = 3'h0;
  localparam logic [2:0] IFS_MODE_ERASE = 3'h1;
  localparam logic [2:0] IFS_MODE_READ = 3'h3;
  localparam logic [2:0] IFS_MODE_UNLOCK = 3'h6;

  // Main control register layout, MSB first
  typedef struct packed {
    logic enFlag;
    logic [2:0] opSel;
    logic unlockTrig;
    logic progStart;
    logic readPermit;
    logic readStart;
  } ifs_ctrl_s;
  localparam ifs_ctrl_s IFS_CTRL_RESET = 8'h00;

  // Flash geometry
  localparam int IFS_PAGE_WORDS = 32;
  localparam int IFS_FLASH_WORDS = 8192;
  localparam int IFS_KEY_IDX_SHIFT = 2;
  localparam logic [4:0] IFS_LAST_IDX = 5'h1F;
  localparam logic [4:0] IFS_ADDR_HIGH_RESET = 5'h00;
  localparam logic [7:0] IFS_BYTE_RESET = 8'h00;
  localparam logic [15:0] IFS_ERASED_WORD = 16'h0000;

  // Timing: read in system clocks, the rest in low-speed clock ticks
  localparam int unsigned IFS_READ_CYCLES = 3;
  localparam int unsigned IFS_UNLOCK_TICKS_DEF = 64;
  localparam int unsigned IFS_ERASE_TICKS_DEF = 128;
  localparam int unsigned IFS_WRITE_TICKS_DEF = 64;

  // Sequencer states, Gray along idle-read-erase-write-settle
  typedef enum logic [2:0] {
    IFS_ST_IDLE = 3'b000,
    IFS_ST_READ = 3'b001,
    IFS_ST_ERASE = 3'b011,
    IFS_ST_WRITE = 3'b010,
    IFS_ST_SETTLE = 3'b110
  } ifs_state_e;

endpackage

// ### ifs_flash_sequencer.sv
// In-application flash programming sequencer with its flash array and register slave.
//
// Behaviour
// R1: Software selects the unlock code in the operation field before triggering unlock.
// R2: Setting unlock trigger in unlock mode starts the unlock window timer.
// R3: Six key registers must hold 00,0D,C3,04,09,40 in order; device compares.
// R4: Window expiry clears the unlock trigger, correct key or not.
// R5: Correct key sets programming enable; wrong key leaves it off until retried.
// R6: Software clearing programming enable disables erase and write at once.
// R7: Write buffer holds 32 sixteen-bit words; page chosen by address bits 12..5.
// R8: Data written low byte then high; high byte loads buffer and advances index.
// R9: Buffer index stops at the last word of the page.
// R10: Erase mode plus program start erases the tagged page; start bit clears after.
// R11: Write mode plus program start copies buffer to the page; start bit clears after.
// R12: Erase covers the whole page; buffer write commits one page, never crossing it.
// R13: Erase and write act only while programming enable is set.
// R14: After a bad verify, clear, reload and rewrite the page without erasing.
// R15: CPU is stalled while a read, erase or write runs.
// R16: Read mode, read permit, address, read start; data lands, read start clears.
// R17: Read start drops three cycles after being set.
// R18: Reads need no unlock and no programming enable.
// R19: Software writes the key promptly after triggering unlock.
// R20: Software verifies by reading back and repeats clear, reload, write on mismatch.
// R21: Non-adjacent words each need a new address and a separate write.
// R22: Software runs the system clock at its top rate while programming.
// R23: Programming enable is set only by hardware; writing zero clears it.
// R24: Each high data write in erase mode tags the current word and advances.
// R25: Buffer clear bit clears the buffer and drops to zero when done.
// R26: Erased words read back as zero.
// R27: Unlock window, erase and write durations are parameters in low-speed ticks.
`timescale 1ns/1ps
module ifs_flash_sequencer
  import ifs_pkg::*;
#(
  parameter int unsigned UNLOCK_TICKS = IFS_UNLOCK_TICKS_DEF,
  parameter int unsigned ERASE_TICKS = IFS_ERASE_TICKS_DEF,
  parameter int unsigned WRITE_TICKS = IFS_WRITE_TICKS_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Low-speed clock, one-cycle pulse per low-speed period
  input wire logic subTick,
  // Avalon-MM slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // CPU stall
  output logic cpuStall
);

  ifs_ctrl_s ctrl_r;
  ifs_ctrl_s wrCtrlVal;
  ifs_state_e state_r;
  logic [7:0] key_r [0:IFS_KEY_COUNT-1];
  logic [15:0] buf_r [0:IFS_PAGE_WORDS-1];
  logic [15:0] flash_r [0:IFS_FLASH_WORDS-1];
  logic [IFS_PAGE_WORDS-1:0] tag_r;
  logic [IFS_KEY_COUNT-1:0] keyWr;
  logic [7:0] addrLow_r, dataLow_r, dataHigh_r, wByte, rdVal, pageSel;
  logic [4:0] addrHigh_r, bufIdx_r, stepIdx_r;
  logic [15:0] tickCnt_r, unlockCnt_r;
  logic [12:0] stepAddr, readAddr;
  logic [5:0] keyOff;
  logic [2:0] keySel;
  logic clearBusy_r, ack_r, busy, wrEn, rdTake, keyOk, unlockDone;
  logic wrCtrl, wrClear, wrAddrLow, wrAddrHigh, wrDataLow, wrDataHigh;
  logic startRead, startErase, startWrite, readDone, progDone;

  assign busy = (state_r != IFS_ST_IDLE);
  assign cpuStall = busy; // R15
  assign wByte = writedata[7:0];
  assign wrCtrlVal = ifs_ctrl_s'(wByte);
  assign pageSel = {addrHigh_r, addrLow_r[7:5]}; // R7
  assign stepAddr = {pageSel, stepIdx_r}; // R12
  assign readAddr = {addrHigh_r, addrLow_r};
  assign keyOff = address - IFS_OFF_KEY_FIRST;
  assign keySel = keyOff[4:2];

  // Bus handshake: one wait cycle per access, held off entirely while an operation runs
  assign waitrequest = (read || write) && !ack_r; // R15
  assign wrEn = write && ack_r && byteenable[0];
  assign rdTake = read && !ack_r && !busy;

  always_ff @(posedge mclk) begin
    if (reset) begin
      ack_r <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      ack_r <= (read || write) && !ack_r && !busy;
      if (rdTake) begin
        readdata <= {24'h00_0000, rdVal};
      end
    end
  end

  // Write decode
  always_comb begin
    {wrCtrl, wrClear, wrAddrLow, wrAddrHigh, wrDataLow, wrDataHigh} = 6'h00;
    keyWr = '0;
    if (wrEn) begin
      if (address == IFS_OFF_CTRL) begin
        wrCtrl = 1'b1;
      end else if (address == IFS_OFF_CLEAR) begin
        wrClear = 1'b1;
      end else if (address == IFS_OFF_ADDR_LOW) begin
        wrAddrLow = 1'b1;
      end else if (address == IFS_OFF_ADDR_HIGH) begin
        wrAddrHigh = 1'b1;
      end else if (address == IFS_OFF_DATA_LOW) begin
        wrDataLow = 1'b1;
      end else if (address == IFS_OFF_DATA_HIGH) begin
        wrDataHigh = 1'b1;
      end else if (address >= IFS_OFF_KEY_FIRST && address <= IFS_OFF_KEY_LAST &&
                   address[1:0] == 2'b00) begin
        keyWr[keySel] = 1'b1;
      end
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rdVal = 8'h00;
    if (address == IFS_OFF_CTRL) begin
      rdVal = ctrl_r;
    end else if (address == IFS_OFF_CLEAR) begin
      rdVal = {7'h00, clearBusy_r};
    end else if (address == IFS_OFF_ADDR_LOW) begin
      rdVal = addrLow_r;
    end else if (address == IFS_OFF_ADDR_HIGH) begin
      rdVal = {3'h0, addrHigh_r};
    end else if (address == IFS_OFF_DATA_LOW) begin
      rdVal = dataLow_r;
    end else if (address == IFS_OFF_DATA_HIGH) begin
      rdVal = dataHigh_r;
    end else if (address >= IFS_OFF_KEY_FIRST && address <= IFS_OFF_KEY_LAST &&
                 address[1:0] == 2'b00) begin
      rdVal = key_r[keySel];
    end
  end

  // Operation starts, decided on the accepted control write
  assign startRead = wrCtrl && wrCtrlVal.readStart && wrCtrlVal.readPermit &&
                     wrCtrlVal.opSel == IFS_MODE_READ; // R16 R18
  assign startErase = wrCtrl && wrCtrlVal.progStart && ctrl_r.enFlag && wrCtrlVal.enFlag &&
                      wrCtrlVal.opSel == IFS_MODE_ERASE; // R10 R13
  assign startWrite = wrCtrl && wrCtrlVal.progStart && ctrl_r.enFlag && wrCtrlVal.enFlag &&
                      wrCtrlVal.opSel == IFS_MODE_WRITE; // R11 R13
  // Key judged whole at window expiry; the first key register is the top pattern byte
  assign keyOk = {key_r[0], key_r[1], key_r[2], key_r[3], key_r[4], key_r[5]} ==
                 IFS_KEY_PATTERN; // R3

  always_ff @(posedge mclk) begin
    if (reset) begin
      key_r <= '{default: IFS_BYTE_RESET};
    end else if (|keyWr) begin
      key_r[keySel] <= wByte;
    end
  end

  // Unlock window timer, counted in low-speed ticks
  assign unlockDone = ctrl_r.unlockTrig && subTick &&
                      unlockCnt_r >= 16'(UNLOCK_TICKS - 1); // R27

  always_ff @(posedge mclk) begin
    if (reset) begin
      unlockCnt_r <= 16'h0000;
    end else if (!ctrl_r.unlockTrig || unlockDone) begin
      unlockCnt_r <= 16'h0000;
    end else if (subTick) begin
      unlockCnt_r <= unlockCnt_r + 16'h0001; // R2
    end
  end

  // Main control register; hardware set and clear come last so they win
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_r <= IFS_CTRL_RESET;
    end else begin
      if (wrCtrl) begin
        ctrl_r.opSel <= wrCtrlVal.opSel;
        ctrl_r.readPermit <= wrCtrlVal.readPermit;
        if (!wrCtrlVal.enFlag) begin
          ctrl_r.enFlag <= 1'b0; // R6 R23
        end
        if (wrCtrlVal.unlockTrig && wrCtrlVal.opSel == IFS_MODE_UNLOCK) begin
          ctrl_r.unlockTrig <= 1'b1; // R2
        end
        if (startErase || startWrite) begin
          ctrl_r.progStart <= 1'b1;
        end
        if (startRead) begin
          ctrl_r.readStart <= 1'b1;
        end
      end
      if (unlockDone) begin
        ctrl_r.unlockTrig <= 1'b0; // R4
        if (keyOk) begin
          ctrl_r.enFlag <= 1'b1; // R5
        end
      end
      if (progDone) begin
        ctrl_r.progStart <= 1'b0; // R10 R11
      end
      if (readDone) begin
        ctrl_r.readStart <= 1'b0; // R16
      end
    end
  end

  // Address registers; the buffer index follows the low address write
  always_ff @(posedge mclk) begin
    if (reset) begin
      addrLow_r <= IFS_BYTE_RESET;
      addrHigh_r <= IFS_ADDR_HIGH_RESET;
    end else begin
      if (wrAddrLow) begin
        addrLow_r <= wByte;
      end
      if (wrAddrHigh) begin
        addrHigh_r <= wByte[4:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      bufIdx_r <= 5'h00;
    end else if (wrAddrLow) begin
      bufIdx_r <= wByte[4:0];
    end else if (wrDataHigh && bufIdx_r != IFS_LAST_IDX &&
                 (ctrl_r.opSel == IFS_MODE_WRITE || ctrl_r.opSel == IFS_MODE_ERASE)) begin
      bufIdx_r <= bufIdx_r + 5'h01; // R8 R9 R24
    end
  end

  // Word data registers, also the landing place of a read
  always_ff @(posedge mclk) begin
    if (reset) begin
      dataLow_r <= IFS_BYTE_RESET;
      dataHigh_r <= IFS_BYTE_RESET;
    end else if (state_r == IFS_ST_READ && stepIdx_r == 5'h00) begin
      {dataHigh_r, dataLow_r} <= flash_r[readAddr]; // R16
    end else begin
      if (wrDataLow) begin
        dataLow_r <= wByte;
      end
      if (wrDataHigh) begin
        dataHigh_r <= wByte;
      end
    end
  end

  // Write buffer; clear takes one cycle after the bit is set
  always_ff @(posedge mclk) begin
    for (int i = 0; i < IFS_PAGE_WORDS; i++) begin
      if (reset || clearBusy_r) begin
        buf_r[i] <= IFS_ERASED_WORD; // R25 R14
      end else if (wrDataHigh && ctrl_r.opSel == IFS_MODE_WRITE &&
                   bufIdx_r == 5'(i)) begin
        buf_r[i] <= {wByte, dataLow_r}; // R8
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      clearBusy_r <= 1'b0;
    end else if (clearBusy_r) begin
      clearBusy_r <= 1'b0; // R25
    end else if (wrClear && wByte[0]) begin
      clearBusy_r <= 1'b1;
    end
  end

  // Erase tags; kept until the erase that uses them is finished
  always_ff @(posedge mclk) begin
    if (reset) begin
      tag_r <= '0;
    end else if (state_r == IFS_ST_ERASE && stepIdx_r == IFS_LAST_IDX) begin
      tag_r <= '0;
    end else if (wrDataHigh && ctrl_r.opSel == IFS_MODE_ERASE) begin
      tag_r[bufIdx_r] <= 1'b1; // R24
    end
  end

  // Sequencer: word steps through the page, then the settle time
  assign readDone = (state_r == IFS_ST_READ) &&
                    stepIdx_r == 5'(IFS_READ_CYCLES - 1); // R17
  assign progDone = (state_r == IFS_ST_SETTLE) && subTick && tickCnt_r <= 16'h0001;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= IFS_ST_IDLE;
    end else begin
      case (state_r)
        IFS_ST_IDLE: begin
          if (startRead) begin
            state_r <= IFS_ST_READ;
          end else if (startErase) begin
            state_r <= IFS_ST_ERASE;
          end else if (startWrite) begin
            state_r <= IFS_ST_WRITE;
          end
        end
        IFS_ST_READ: begin
          if (readDone) begin
            state_r <= IFS_ST_IDLE;
          end
        end
        IFS_ST_ERASE, IFS_ST_WRITE: begin
          if (stepIdx_r == IFS_LAST_IDX) begin
            state_r <= IFS_ST_SETTLE;
          end
        end
        IFS_ST_SETTLE: begin
          if (progDone) begin
            state_r <= IFS_ST_IDLE;
          end
        end
        default: begin
          state_r <= IFS_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      stepIdx_r <= 5'h00;
    end else if (state_r == IFS_ST_IDLE || state_r == IFS_ST_SETTLE || readDone) begin
      stepIdx_r <= 5'h00;
    end else begin
      stepIdx_r <= stepIdx_r + 5'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tickCnt_r <= 16'h0000;
    end else if (state_r == IFS_ST_ERASE && stepIdx_r == IFS_LAST_IDX) begin
      tickCnt_r <= 16'(ERASE_TICKS); // R27
    end else if (state_r == IFS_ST_WRITE && stepIdx_r == IFS_LAST_IDX) begin
      tickCnt_r <= 16'(WRITE_TICKS); // R27
    end else if (state_r == IFS_ST_SETTLE && subTick && tickCnt_r != 16'h0000) begin
      tickCnt_r <= tickCnt_r - 16'h0001;
    end
  end

  // Flash array, not reset; writes only set bits, so a rewrite needs no erase.
  // Tags cannot be set while busy and drop only after the last erased word.
  always_ff @(posedge mclk) begin
    if (state_r == IFS_ST_ERASE && |tag_r) begin
      flash_r[stepAddr] <= IFS_ERASED_WORD; // R10 R12 R26
    end else if (state_r == IFS_ST_WRITE) begin
      flash_r[stepAddr] <= flash_r[stepAddr] | buf_r[stepIdx_r]; // R11 R12 R14
    end
  end

endmodule

// ### ifs_flash_sequencer_asserts.sv
// Port-level checker for the flash programming sequencer, bound to its top module.
`timescale 1ns/1ps
module ifs_flash_sequencer_asserts
  import ifs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Low-speed tick
  input wire logic subTick,
  // Avalon-MM slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // CPU stall
  input wire logic cpuStall
);
  default clocking cbMain @(posedge mclk);
  endclocking
  default disable iff (reset);

  logic busReq;
  logic mapped;
  assign busReq = read | write;
  assign mapped = (address[1:0] == 2'h0) && (address <= IFS_OFF_KEY_LAST);

  // Read mode, permit and start in one write, flag bit ignored
  sequence seqReadTaken;
    write && !waitrequest && address == IFS_OFF_CTRL && byteenable[0]
      && writedata[6:0] == 7'h33;
  endsequence
  sequence seqStallThree;
    cpuStall [*3] ##1 !cpuStall;
  endsequence

  AST_IDLE_NO_WAIT: assert property (!busReq |-> !waitrequest)
    else $error("waitrequest high with no request");
  AST_STALL_HOLDS_BUS: assert property (cpuStall && busReq |-> waitrequest)
    else $error("request answered while an operation runs");
  AST_ACK_ONE_CYCLE: assert property (busReq && !waitrequest |=> waitrequest || !busReq)
    else $error("waitrequest low for more than one cycle");
  AST_READ_STALL: assert property (seqReadTaken |=> seqStallThree)
    else $error("read operation stall is not three cycles");
  AST_FREE_ACK: assert property (busReq && !cpuStall |-> ##[0:2] !waitrequest)
    else $error("idle sequencer did not answer a request");
  AST_STALL_BOUNDED: assert property ($rose(cpuStall) |-> ##[1:600] !cpuStall)
    else $error("operation stall did not end");
  AST_READDATA_HOLD: assert property ($changed(readdata) |-> $past(read))
    else $error("readdata changed without a read");
  AST_READ_ZERO_FILL: assert property (read && !waitrequest |->
      readdata[31:8] == 24'h0 && (mapped || readdata[7:0] == 8'h00))
    else $error("read data upper bits or unmapped value not zero");
endmodule

bind ifs_flash_sequencer ifs_flash_sequencer_asserts u_asserts (.mclk(mclk), .reset(reset),
  .subTick(subTick), .address(address), .read(read), .write(write),
  .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .cpuStall(cpuStall));

// ### ifs_flash_sequencer_tb_top.sv
// Self-checking testbench for the flash programming sequencer over its register bus.
`timescale 1ns/1ps
module ifs_flash_sequencer_tb_top
  import ifs_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic subTick = 1'b0;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] beSel = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic cpuStall;
  logic [1:0] tickCnt = 2'h0;
  logic [7:0] rd8;
  logic [15:0] rd16;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;

  // Window of 16 ticks leaves room for the six key writes at four clocks a tick
  ifs_flash_sequencer #(.UNLOCK_TICKS(16), .ERASE_TICKS(4), .WRITE_TICKS(4)) u_dut (
    .mclk(mclk), .reset(reset), .subTick(subTick), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .cpuStall(cpuStall));

  always #12.5 mclk = ~mclk;

  task report_and_stop();
    if (err_total == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    tickCnt <= tickCnt + 2'h1;
    subTick <= (tickCnt == 2'h3);
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      report_and_stop();
    end
  end

  task check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request stands until waitrequest is seen low at a rising edge; one idle
  // edge follows so the next call never raises a strobe in the same step
  task bus_wr(input logic [5:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= beSel;
    write <= 1'b1;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    write <= 1'b0;
    @(posedge mclk);
  endtask

  task bus_rd(input logic [5:0] a, output logic [7:0] d);
    address <= a;
    read <= 1'b1;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    d = readdata[7:0];
    read <= 1'b0;
    @(posedge mclk);
  endtask

  task rd_chk(input logic [5:0] a, input logic [7:0] exp);
    bus_rd(a, rd8);
    check({8'h00, rd8}, {8'h00, exp});
  endtask

  task wr_word(input logic [15:0] w);
    bus_wr(IFS_OFF_DATA_LOW, w[7:0]);
    bus_wr(IFS_OFF_DATA_HIGH, w[15:8]);
  endtask

  task word_rd(input logic [7:0] lo, input logic fl, input logic [15:0] exp);
    bus_wr(IFS_OFF_ADDR_LOW, lo);
    bus_wr(IFS_OFF_ADDR_HIGH, 8'h03);
    bus_wr(IFS_OFF_CTRL, {fl, 7'h33});
    rd_chk(IFS_OFF_CTRL, {fl, 7'h32});
    bus_rd(IFS_OFF_DATA_LOW, rd16[7:0]);
    bus_rd(IFS_OFF_DATA_HIGH, rd16[15:8]);
    check(rd16, exp);
  endtask

  // A nonzero flip spoils the last key byte
  task unlock(input logic [7:0] flip);
    int k;
    bus_wr(IFS_OFF_CTRL, 8'h68);
    rd_chk(IFS_OFF_CTRL, 8'h68);
    for (k = 0; k < IFS_KEY_COUNT; k++) begin
      bus_wr(6'(IFS_OFF_KEY_FIRST + 4 * k),
        IFS_KEY_PATTERN[47 - 8 * k -: 8] ^ ((k == 5) ? flip : 8'h00));
    end
    do bus_rd(IFS_OFF_CTRL, rd8); while (rd8[3] !== 1'b0);
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd_chk(IFS_OFF_CTRL, IFS_CTRL_RESET);
    bus_wr(IFS_OFF_CTRL, 8'h80);
    rd_chk(IFS_OFF_CTRL, 8'h00);
    bus_wr(IFS_OFF_CTRL, 8'h14);
    rd_chk(IFS_OFF_CTRL, 8'h10);
    rd_chk(6'h30, 8'h00);
    rd_chk(6'h05, 8'h00);
    unlock(8'h01);
    check({8'h00, rd8}, 16'h0060);
    unlock(8'h00);
    check({8'h00, rd8}, 16'h00E0);
    // Erase page 0x1A; the extra tag write must not leave the page
    bus_wr(IFS_OFF_CTRL, 8'h90);
    bus_wr(IFS_OFF_ADDR_LOW, 8'h40);
    bus_wr(IFS_OFF_ADDR_HIGH, 8'h03);
    repeat (33) wr_word(16'h0000);
    bus_wr(IFS_OFF_CTRL, 8'h94);
    rd_chk(IFS_OFF_CTRL, 8'h90);
    word_rd(8'h40, 1'b1, IFS_ERASED_WORD);
    word_rd(8'h5F, 1'b1, IFS_ERASED_WORD);
    // Three words from index 30: the third lands on the last word
    bus_wr(IFS_OFF_CTRL, 8'h80);
    bus_wr(IFS_OFF_ADDR_LOW, 8'h5E);
    bus_wr(IFS_OFF_ADDR_HIGH, 8'h03);
    // A write without its low byte lane is acknowledged and ignored
    beSel = 4'hE;
    bus_wr(IFS_OFF_ADDR_HIGH, 8'h1C);
    beSel = 4'hF;
    rd_chk(IFS_OFF_ADDR_HIGH, 8'h03);
    wr_word(16'hA55A);
    wr_word(16'h1234);
    wr_word(16'h0F0F);
    bus_wr(IFS_OFF_CTRL, 8'h84);
    rd_chk(IFS_OFF_CTRL, 8'h80);
    word_rd(8'h5E, 1'b1, 16'hA55A);
    word_rd(8'h5F, 1'b1, 16'h0F0F);
    word_rd(8'h40, 1'b1, 16'h0000);
    // Retry after a failed verify, without erasing
    bus_wr(IFS_OFF_CLEAR, 8'h01);
    rd_chk(IFS_OFF_CLEAR, 8'h00);
    bus_wr(IFS_OFF_CTRL, 8'h80);
    bus_wr(IFS_OFF_ADDR_LOW, 8'h40);
    wr_word(16'hC3C3);
    bus_wr(IFS_OFF_CTRL, 8'h84);
    rd_chk(IFS_OFF_CTRL, 8'h80);
    word_rd(8'h40, 1'b1, 16'hC3C3);
    word_rd(8'h5E, 1'b1, 16'hA55A);
    // Software disable, then a refused write and a read without the flag
    bus_wr(IFS_OFF_CTRL, 8'h00);
    rd_chk(IFS_OFF_CTRL, 8'h00);
    bus_wr(IFS_OFF_CTRL, 8'h84);
    rd_chk(IFS_OFF_CTRL, 8'h00);
    word_rd(8'h40, 1'b0, 16'hC3C3);
    report_and_stop();
  end
endmodule
